// ==== core/ddf_fifo.sv ====
// Deep 9-bit FIFO with sampled write/read clocks, status flags and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Mode pin low during reset selects standard mode with empty and full flags.
// - Mode pin high during reset selects fall-through mode with ready flags.
// - Fall-through: first word reaches outputs after three read-clock edges unrequested.
// - Standard mode: every word, first included, needs read enable at a read edge.
// - Input word captured at each write-clock edge with write enable low.
// - Empty flag rises once a word sits in an empty memory.
// - Almost-empty flag high at n+1 words, low again at n words.
// - Half-full flag low from half depth plus one words, high below it.
// - Almost-full flag low at depth minus m words; reads raise it again.
// - Full flag low at depth words; writes then ignored.
// - First read from a full memory raises the full flag again.
// - Empty flag low after last read; reads ignored while empty.
// - Empty flag two read-edge stages, full flag two write-edge stages.
// - Load pin high at reset: serial loading, offsets default to 3FF. The code has no serial load path; offsets are written over AXI4-Lite.
// - Load pin low at reset: parallel loading, offsets default to 07F. The code has no parallel load path; offsets are written over AXI4-Lite.
//////////////////////////////////////////////////////////////////////////////
module ddf_fifo #(
   parameter int DEPTH = ddf_pkg::DEPTH_SMALL
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      write_clk_pin,
   input  wire logic                      read_clk_pin,
   input  wire logic                      write_en_n,
   input  wire logic                      read_en_n,
   input  wire logic [ddf_pkg::DATA_W-1:0] data_in,
   input  wire logic                      mode_select_serial_in,
   input  wire logic                      offset_load_n,
   output logic      [ddf_pkg::DATA_W-1:0] data_out,
   output logic                           empty_flag_n,
   output logic                           full_flag_n,
   output logic                           almost_empty_flag_n,
   output logic                           almost_full_flag_n,
   output logic                           half_full_flag_n,
   output logic                           input_ready_n,
   output logic                           irq,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic      [1:0]                s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic      [31:0]               s_axi_rdata,
   output logic      [1:0]                s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   localparam int AW    = $clog2(DEPTH);
   localparam int PW    = AW + 1;
   localparam int OW    = ddf_pkg::OFF_W;
   localparam int DW    = ddf_pkg::DATA_W;
   localparam int EW    = ddf_pkg::EVT_W;
   localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
   localparam logic [PW-1:0] HALF_CNT = PW'(DEPTH / 2 + 1);

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; data shares the clock-pin delay so they stay aligned
   logic [DW+4:0] pin_s1_r;
   logic [DW+4:0] pin_s2_r;
   logic          wclk_q_r;
   logic          rclk_q_r;
   always_ff @(posedge aclk) begin
      pin_s1_r <= {write_clk_pin, read_clk_pin, write_en_n, read_en_n,
                   mode_select_serial_in, data_in};
      pin_s2_r <= pin_s1_r;
      wclk_q_r <= pin_s2_r[DW+4];
      rclk_q_r <= pin_s2_r[DW+3];
   end
   wire           wclk_s   = pin_s2_r[DW+4];
   wire           rclk_s   = pin_s2_r[DW+3];
   wire           wen_n_s  = pin_s2_r[DW+2];
   wire           ren_n_s  = pin_s2_r[DW+1];
   wire           mode_s   = pin_s2_r[DW];
   wire [DW-1:0]  din_s    = pin_s2_r[DW-1:0];
   wire           wr_tick  = wclk_s & ~wclk_q_r;
   wire           rd_tick  = rclk_s & ~rclk_q_r;

   //////////////////////////////////////////////////////////////////////////
   // Reset-time straps; load pin has its own two stages
   logic          ld_s1_r;
   logic          ld_s2_r;
   logic          fall_through_mode_r;
   logic          serial_r;
   logic [OW-1:0] empty_off_r;
   logic [OW-1:0] full_off_r;
   always_ff @(posedge aclk) begin
      ld_s1_r <= offset_load_n;
      ld_s2_r <= ld_s1_r;
   end

   //////////////////////////////////////////////////////////////////////////
   // Storage and pointers
   logic [DW-1:0]  mem [DEPTH];
   logic [PW-1:0]  wr_ptr_r;
   logic [PW-1:0]  rd_ptr_r;
   logic [DW-1:0]  data_out_r;
   ddf_pkg::ddf_fall_e fall_r;
   ddf_pkg::ddf_fall_e fall_nxt;

   wire [PW-1:0] level     = wr_ptr_r - rd_ptr_r;
   wire          mem_empty = (level == '0);
   wire          mem_full  = (level == FULL_CNT);
   wire          wr_req    = wr_tick & ~wen_n_s;
   wire          push      = wr_req & ~mem_full;
   wire          std_pop   = ~fall_through_mode_r & rd_tick & ~ren_n_s & ~mem_empty;
   wire          fall_load = fall_through_mode_r & rd_tick & ~mem_empty &
                             ((fall_r == ddf_pkg::FALL_2) |
                              ((fall_r == ddf_pkg::FALL_OUT) & ~ren_n_s));
   wire          pop       = std_pop | fall_load;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= din_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r   <= '0;
         rd_ptr_r   <= '0;
         data_out_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + PW'(1);
         end
         if (pop) begin
            rd_ptr_r   <= rd_ptr_r + PW'(1);
            data_out_r <= mem[rd_ptr_r[AW-1:0]];
         end
      end
   end
   assign data_out = data_out_r;

   //////////////////////////////////////////////////////////////////////////
   // Fall-through output stage: counts read edges before first word shows
   always_comb begin
      fall_nxt = fall_r;
      case (fall_r)
         ddf_pkg::FALL_IDLE: begin
            if (rd_tick && !mem_empty) fall_nxt = ddf_pkg::FALL_1;
         end
         ddf_pkg::FALL_1: begin
            if (rd_tick) fall_nxt = ddf_pkg::FALL_2;
         end
         ddf_pkg::FALL_2: begin
            if (rd_tick) fall_nxt = ddf_pkg::FALL_OUT;
         end
         ddf_pkg::FALL_OUT: begin
            if (rd_tick && !ren_n_s && mem_empty) fall_nxt = ddf_pkg::FALL_IDLE;
         end
         default: fall_nxt = ddf_pkg::FALL_IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Flags; empty/full run two stages on their own side's edges
   logic ef_s1_r, ef_s2_r, ff_s1_r, ff_s2_r, ir_s1_r, ir_s2_r;
   logic pae_r, paf_r, hf_r;
   wire  full_rel = ~mem_full;
   // Compared at 32 bits so an offset larger than the depth never wraps
   wire [31:0] level_w = {{(32-PW){1'b0}}, level};
   wire [31:0] eoff_w  = {{(32-OW){1'b0}}, empty_off_r};
   wire [31:0] foff_w  = {{(32-OW){1'b0}}, full_off_r};
   wire        pae_nxt = level_w > eoff_w;
   wire        paf_nxt = (level_w + foff_w) < 32'(DEPTH);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fall_r  <= ddf_pkg::FALL_IDLE;
         ef_s1_r <= 1'b0;
         ef_s2_r <= 1'b0;
         ff_s1_r <= 1'b1;
         ff_s2_r <= 1'b1;
         ir_s1_r <= 1'b0;
         ir_s2_r <= 1'b0;
         pae_r   <= 1'b0;
         paf_r   <= 1'b1;
         hf_r    <= 1'b1;
      end else begin
         fall_r <= fall_nxt;
         if (rd_tick) begin
            ef_s1_r <= ~mem_empty;
            ef_s2_r <= ef_s1_r;
            pae_r   <= pae_nxt;
         end
         if (wr_tick) begin
            ff_s1_r <= full_rel;
            ff_s2_r <= ff_s1_r;
            ir_s1_r <= mem_full;
            ir_s2_r <= ir_s1_r;
            paf_r   <= paf_nxt;
         end
         if (rd_tick | wr_tick) begin
            hf_r <= (level < HALF_CNT);
         end
      end
   end

   // Shared pins: empty shows output-ready, full shows input-ready in fall-through
   assign empty_flag_n        = fall_through_mode_r ? (fall_r != ddf_pkg::FALL_OUT) : ef_s2_r;
   assign full_flag_n         = fall_through_mode_r ? ir_s2_r : ff_s2_r;
   assign input_ready_n       = fall_through_mode_r ? ir_s2_r : 1'b1;
   assign almost_empty_flag_n = pae_r;
   assign almost_full_flag_n  = paf_r;
   assign half_full_flag_n    = hf_r;

   //////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic          aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [7:0]    awaddr_r;
   logic [31:0]   wdata_r, rdata_r;
   logic [3:0]    wstrb_r;
   logic [1:0]    bresp_r, rresp_r;
   logic [EW-1:0] irq_stat_r, irq_mask_r;
   logic [4:0]    flag_q_r;

   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready  = ~w_held_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   wire        do_write = aw_held_r & w_held_r & ~bvalid_r;
   wire        do_read  = s_axi_arvalid & ~rvalid_r;
   wire [31:0] wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire        wr_clear = do_write & (awaddr_r == ddf_pkg::REG_IRQ_STAT);
   wire        wr_mask  = do_write & (awaddr_r == ddf_pkg::REG_IRQ_MASK);
   wire        wr_eoff  = do_write & (awaddr_r == ddf_pkg::REG_EMPTY_OF);
   wire        wr_foff  = do_write & (awaddr_r == ddf_pkg::REG_FULL_OF);
   wire        wr_hit   = wr_clear | wr_mask | wr_eoff | wr_foff;
   wire [31:0] w_bits   = wdata_r & wmask;
   wire [31:0] eoff_new = ({{(32-OW){1'b0}}, empty_off_r} & ~wmask) | w_bits;
   wire [31:0] foff_new = ({{(32-OW){1'b0}}, full_off_r} & ~wmask) | w_bits;

   wire [6:0]  flag_word = {serial_r, fall_through_mode_r, half_full_flag_n, almost_full_flag_n,
                            almost_empty_flag_n, full_flag_n, empty_flag_n};
   wire        rd_hit   = (s_axi_araddr == ddf_pkg::REG_FLAGS) |
                          (s_axi_araddr == ddf_pkg::REG_IRQ_STAT) |
                          (s_axi_araddr == ddf_pkg::REG_IRQ_MASK) |
                          (s_axi_araddr == ddf_pkg::REG_EMPTY_OF) |
                          (s_axi_araddr == ddf_pkg::REG_FULL_OF) |
                          (s_axi_araddr == ddf_pkg::REG_LEVEL);
   wire [31:0] rd_mux   =
      (s_axi_araddr == ddf_pkg::REG_FLAGS)    ? {25'h0, flag_word} :
      (s_axi_araddr == ddf_pkg::REG_IRQ_STAT) ? {{(32-EW){1'b0}}, irq_stat_r} :
      (s_axi_araddr == ddf_pkg::REG_IRQ_MASK) ? {{(32-EW){1'b0}}, irq_mask_r} :
      (s_axi_araddr == ddf_pkg::REG_EMPTY_OF) ? {{(32-OW){1'b0}}, empty_off_r} :
      (s_axi_araddr == ddf_pkg::REG_FULL_OF)  ? {{(32-OW){1'b0}}, full_off_r} :
      (s_axi_araddr == ddf_pkg::REG_LEVEL)    ? {{(32-PW){1'b0}}, level} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         bresp_r   <= ddf_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? ddf_pkg::RESP_OKAY : ddf_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= ddf_pkg::RESP_OKAY;
      end else if (do_read) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_hit ? ddf_pkg::RESP_OKAY : ddf_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Straps caught while reset is held, offsets writable afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fall_through_mode_r      <= mode_s;
         serial_r    <= ld_s2_r;
         empty_off_r <= ld_s2_r ? ddf_pkg::OFF_DEF_SERIAL : ddf_pkg::OFF_DEF_PARALLEL;
         full_off_r  <= ld_s2_r ? ddf_pkg::OFF_DEF_SERIAL : ddf_pkg::OFF_DEF_PARALLEL;
      end else begin
         if (wr_eoff) empty_off_r <= eoff_new[OW-1:0];
         if (wr_foff) full_off_r <= foff_new[OW-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupts: flag edges and refused writes; a new event beats a same-cycle clear
   wire [4:0]    flag_now = {paf_r, hf_r, full_flag_n, empty_flag_n, 1'b0};
   wire [EW-1:0] evt;
   assign evt[ddf_pkg::EVT_EMPTY]  = flag_q_r[1] & ~flag_now[1];
   assign evt[ddf_pkg::EVT_FULL]   = flag_q_r[2] & ~flag_now[2];
   assign evt[ddf_pkg::EVT_HALF]   = flag_q_r[3] & ~flag_now[3];
   assign evt[ddf_pkg::EVT_AFULL]  = flag_q_r[4] & ~flag_now[4];
   assign evt[ddf_pkg::EVT_REFUSE] = wr_req & mem_full;
   wire [EW-1:0] clr_bits = wr_clear ? w_bits[EW-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
         irq_mask_r <= ddf_pkg::IRQ_MASK_RST;
         // Idle levels of the strapped mode, so release shows no false edge
         flag_q_r   <= flag_now;
      end else begin
         flag_q_r   <= flag_now;
         irq_stat_r <= (irq_stat_r & ~clr_bits) | evt;
         if (wr_mask) irq_mask_r <= w_bits[EW-1:0];
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   push_advance_a: assert property (push |=> wr_ptr_r == $past(wr_ptr_r) + PW'(1))
      else $error("write pointer did not advance on accepted write");
   full_refuse_a: assert property (mem_full && wr_req |=> $stable(wr_ptr_r))
      else $error("write accepted while full");
   empty_noread_a: assert property (mem_empty && rd_tick |=> $stable(rd_ptr_r))
      else $error("read performed while empty");
   std_request_a: assert property (!fall_through_mode_r && !(rd_tick && !ren_n_s) |=> $stable(data_out_r))
      else $error("standard mode output changed without read request");
   fall_three_a: assert property (fall_r == ddf_pkg::FALL_IDLE && rd_tick && !mem_empty
      |=> fall_r == ddf_pkg::FALL_1)
      else $error("fall-through did not start counting read edges");
   full_stage_a: assert property (!fall_through_mode_r && wr_tick |=> full_flag_n == $past(ff_s1_r))
      else $error("full flag not two stages behind");
   empty_two_a: assert property (!fall_through_mode_r && rd_tick |=> empty_flag_n == $past(ef_s1_r))
      else $error("empty flag not two stages behind");
   almost_empty_a: assert property (rd_tick |=> pae_r == ($past(level_w) > $past(eoff_w)))
      else $error("almost-empty flag wrong for level");
   half_full_a: assert property (rd_tick || wr_tick |=> hf_r == ($past(level) < HALF_CNT))
      else $error("half-full flag wrong for level");
   mode_hold_a: assert property (aresetn |=> $stable(fall_through_mode_r) && $stable(serial_r))
      else $error("mode changed outside reset");
   default_off_a: assert property ($rose(aresetn) |-> empty_off_r == full_off_r &&
      (serial_r ? empty_off_r == ddf_pkg::OFF_DEF_SERIAL
                : empty_off_r == ddf_pkg::OFF_DEF_PARALLEL))
      else $error("offset defaults do not follow load strap");

   full_seen_c:  cover property (mem_full && wr_req);
   fall_out_c:   cover property (fall_r == ddf_pkg::FALL_2 ##[1:40] fall_r == ddf_pkg::FALL_OUT);
   irq_clear_c:  cover property (irq ##1 !irq);
endmodule
`default_nettype wire

// ==== common/ddf_pkg.sv ====
// Constants shared by the deep dual-clock FIFO flag block
package ddf_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] REG_FLAGS    = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_EMPTY_OF = 8'h0C;
   localparam logic [7:0] REG_FULL_OF  = 8'h10;
   localparam logic [7:0] REG_LEVEL    = 8'h14;

   // Flags register field positions
   localparam int FLG_EMPTY  = 0;
   localparam int FLG_FULL   = 1;
   localparam int FLG_AEMPTY = 2;
   localparam int FLG_AFULL  = 3;
   localparam int FLG_HALF   = 4;
   localparam int FLG_FALL_THROUGH_MODE   = 5;
   localparam int FLG_SERIAL = 6;

   // Interrupt event bit positions
   localparam int EVT_EMPTY  = 0;
   localparam int EVT_FULL   = 1;
   localparam int EVT_HALF   = 2;
   localparam int EVT_AFULL  = 3;
   localparam int EVT_REFUSE = 4;
   localparam int EVT_W      = 5;

   // Geometry
   localparam int DATA_W = 9;
   localparam int OFF_W  = 19;
   localparam int DEPTH_SMALL = 262144;

   // Offset defaults chosen by the load pin at reset
   localparam logic [OFF_W-1:0] OFF_DEF_SERIAL   = 19'h0_03FF;
   localparam logic [OFF_W-1:0] OFF_DEF_PARALLEL = 19'h0_007F;
   localparam logic [EVT_W-1:0] IRQ_MASK_RST     = 5'h00;

   // Read-clock edges before the first word falls through
   localparam int FALL_EDGES = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Fall-through output stage, Gray along the usual path
   typedef enum logic [1:0] {
      FALL_IDLE = 2'h0,
      FALL_1    = 2'h1,
      FALL_2    = 2'h3,
      FALL_OUT  = 2'h2
   } ddf_fall_e;
endpackage

// ==== tb/ddf_partner.sv ====
// Writer and reader model on their own free-running link clocks
`timescale 1ns/10ps
`default_nettype none
module ddf_partner (
   output logic                       write_clk_pin,
   output logic                       read_clk_pin,
   output logic                       write_en_n,
   output logic                       read_en_n,
   output logic [ddf_pkg::DATA_W-1:0] data_in
);
   initial begin
      write_clk_pin = 1'b0;
      forever #24 write_clk_pin = ~write_clk_pin;
   end
   // Odd start offset puts each read-clock edge 7 ns after the write-clock edge, same period
   initial begin
      read_clk_pin = 1'b0;
      #7;
      forever #24 read_clk_pin = ~read_clk_pin;
   end
   initial begin
      write_en_n = 1'b1;
      read_en_n  = 1'b1;
      data_in    = 9'h155;
   end
   // Released data goes to its inverse so a stale word never looks valid
   // Driven on falling edges so exactly one rising edge sees the enable
   task automatic push(input logic [ddf_pkg::DATA_W-1:0] w);
      @(negedge write_clk_pin);
      write_en_n <= 1'b0;
      data_in    <= w;
      @(negedge write_clk_pin);
      write_en_n <= 1'b1;
      data_in    <= ~w;
   endtask
   task automatic pop();
      @(negedge read_clk_pin);
      read_en_n <= 1'b0;
      @(negedge read_clk_pin);
      read_en_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: AXI register access plus pin traffic through the partner
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int D  = 16;
   localparam int NE = 2;
   localparam int MF = 3;
   logic        aclk, aresetn, mode_select_serial_in, offset_load_n, irq;
   logic        write_clk_pin, read_clk_pin, write_en_n, read_en_n;
   logic [8:0]  data_in, data_out;
   logic        empty_flag_n, full_flag_n, almost_empty_flag_n;
   logic        almost_full_flag_n, half_full_flag_n, input_ready_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          error_cnt = 0;
   int          checked = 0;
   int          cycles = 0;
   ddf_fifo #(.DEPTH(D)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .write_clk_pin(write_clk_pin), .read_clk_pin(read_clk_pin), .write_en_n(write_en_n),
      .read_en_n(read_en_n), .data_in(data_in), .mode_select_serial_in(mode_select_serial_in),
      .offset_load_n(offset_load_n), .data_out(data_out), .empty_flag_n(empty_flag_n),
      .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
      .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n),
      .input_ready_n(input_ready_n), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   ddf_partner partner_u (.write_clk_pin(write_clk_pin), .read_clk_pin(read_clk_pin),
      .write_en_n(write_en_n), .read_en_n(read_en_n), .data_in(data_in));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", s_axi_bresp, ddf_pkg::RESP_OKAY);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Straps held through the whole reset, as the far side must
   task automatic do_reset(input logic mode, input logic ld);
      aresetn <= 1'b0;
      mode_select_serial_in <= mode;
      offset_load_n <= ld;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   // Room for two flag stages on either link clock plus synchronisers
   task automatic settle();
      repeat (40) @(posedge aclk);
   endtask
   task automatic flags(input int c);
      chk("empty", empty_flag_n, c > 0);
      chk("almost_empty", almost_empty_flag_n, c >= NE + 1);
      chk("half_full", half_full_flag_n, c < D / 2 + 1);
      chk("almost_full", almost_full_flag_n, c < D - MF);
      chk("full", full_flag_n, c < D);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      mode_select_serial_in = 1'b0;
      offset_load_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      @(posedge aclk);
      do_reset(1'b0, 1'b0);
      axi_rd(ddf_pkg::REG_EMPTY_OF, rd, rsp);
      chk("empty_offset", rd, 32'h0000_007F);
      axi_rd(ddf_pkg::REG_FULL_OF, rd, rsp);
      chk("full_offset", rd, 32'h0000_007F);
      axi_rd(ddf_pkg::REG_FLAGS, rd, rsp);
      chk("mode", rd[ddf_pkg::FLG_FALL_THROUGH_MODE], 1'b0);
      axi_rd(ddf_pkg::REG_IRQ_MASK, rd, rsp);
      chk("mask", rd, 32'h0000_0000);
      axi_rd(8'h3C, rd, rsp);
      chk("unmapped", rsp, ddf_pkg::RESP_SLVERR);
      axi_wr(ddf_pkg::REG_EMPTY_OF, NE);
      axi_wr(ddf_pkg::REG_FULL_OF, MF);
      axi_wr(ddf_pkg::REG_IRQ_STAT, 32'h0000_001F);
      settle();
      flags(0);
      partner_u.push(9'h1C3);
      settle();
      flags(1);
      chk("unrequested", data_out, 9'h000);
      partner_u.pop();
      settle();
      chk("first_word", data_out, 9'h1C3);
      flags(0);
      for (int i = 0; i < D; i++) begin
         partner_u.push(9'h100 + 9'(i));
         settle();
         flags(i + 1);
      end
      partner_u.push(9'h0AA);
      settle();
      flags(D);
      chk("input_ready_std", input_ready_n, 1'b1);
      axi_rd(ddf_pkg::REG_LEVEL, rd, rsp);
      chk("level", rd, D);
      chk("irq_masked", irq, 1'b0);
      axi_wr(ddf_pkg::REG_IRQ_MASK, 32'h1 << ddf_pkg::EVT_REFUSE);
      repeat (2) @(posedge aclk);
      chk("irq_raised", irq, 1'b1);
      axi_rd(ddf_pkg::REG_IRQ_STAT, rd, rsp);
      chk("refuse_event", rd[ddf_pkg::EVT_REFUSE], 1'b1);
      axi_wr(ddf_pkg::REG_IRQ_STAT, 32'h0000_001F);
      repeat (2) @(posedge aclk);
      chk("irq_cleared", irq, 1'b0);
      for (int i = 0; i < D; i++) begin
         partner_u.pop();
         settle();
         chk("drain", data_out, 9'h100 + 9'(i));
         flags(D - 1 - i);
      end
      partner_u.pop();
      settle();
      chk("read_empty", data_out, 9'h10F);
      do_reset(1'b1, 1'b1);
      axi_rd(ddf_pkg::REG_EMPTY_OF, rd, rsp);
      chk("serial_offset", rd, 32'h0000_03FF);
      axi_rd(ddf_pkg::REG_FLAGS, rd, rsp);
      chk("fall_mode", rd[ddf_pkg::FLG_FALL_THROUGH_MODE], 1'b1);
      partner_u.push(9'h0E5);
      repeat (5) @(posedge read_clk_pin);
      settle();
      chk("fall_through", data_out, 9'h0E5);
      chk("output_ready", empty_flag_n, 1'b0);
      chk("input_ready", input_ready_n, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
